// File: verilog/mciw_map.vh
/*
  Register map, field positions, reset values and timing figures of the
  interrupt controller and watchdog block.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef MCIW_MAP_VH
`define MCIW_MAP_VH

`define MCIW_CLK_MHZ      25

`define MCIW_OFF_FLAG     8'h00
`define MCIW_OFF_ENABLE   8'h04
`define MCIW_OFF_PWRCTL   8'h08
`define MCIW_OFF_STATUS   8'h0C
`define MCIW_OFF_WDTCTL   8'h10
`define MCIW_OFF_EXTCTL   8'h14
`define MCIW_OFF_CHGEN    8'h18

`define MCIW_NSRC         12
`define MCIW_B_TMR0       0
`define MCIW_B_TMR1       1
`define MCIW_B_TMR4       2
`define MCIW_B_TMR5       3
`define MCIW_B_PCHG       4
`define MCIW_B_EXT0       5
`define MCIW_B_WDT        6
`define MCIW_B_EXT1       7
`define MCIW_B_EXT2       8
`define MCIW_B_LVD        9
`define MCIW_B_ADC        10
`define MCIW_B_NVM        11

`define MCIW_B_RUN_EN     7
`define MCIW_B_TO_N       4
`define MCIW_B_GIE        0
`define MCIW_B_PSWDT      3

`define MCIW_RST_PWRCTL   8'h80
`define MCIW_RST_WDTCTL   4'h0
`define MCIW_RST_EXTCTL   8'h38
`define MCIW_RST_CHGEN    16'h0000

`define MCIW_VEC_SW       11'h001
`define MCIW_VEC_HW       11'h008

`define MCIW_WDT_T0_US    3500
`define MCIW_WDT_T1_US    15000
`define MCIW_WDT_T2_US    60000
`define MCIW_WDT_T3_US    250000

`endif

// File: verilog/mciw_irq_wdt.v
/*
  Interrupt controller with watchdog timeout logic, APB register slave.
  Assumes: CPU core pulses one-cycle instruction strobes on pclk; timer,
  CAPTURE_COMPARE_UNIT, ADC and NVM strobes are pclk-synchronous; pins and analog levels
  are asynchronous. Watchdog time base is divided down from pclk.
*/
// Local design decisions: the APB slave port and the register offsets.
// Behaviour
// R1: Software interrupt vectors 0x001, clears global enable.
// R2: Hardware event sets sticky flag until written 0.
// R3: Enabled flag with global enable vectors 0x008.
// R4: Enable/disable instructions set/clear global enable.
// R5: Return instruction sets global enable again.
// R6: Flag reads back only while enabled.
// R7: Firmware may re-enable first for nesting.
// R8: Firmware avoids enable right before return.
// R9: Timer0 wrap sets timer0 flag.
// R10: Timer1/timer4 underflow set their flags.
// R11: Timer5 source becomes capture/compare event.
// R12: Watchdog interrupt option sets flag bit 6.
// R13: Timeout clears status; config picks reset/interrupt.
// R14: Base timeout 3.5/15/60/250 ms selectable.
// R15: Prescaler divides 1..128 reset, 2..256 interrupt.
// R16: Clear-watchdog clears counters, sets timeout status (code sets the status only while ps_wdt is set).
// R17: Run enable bit gates configured watchdog.
// R18: Enabled input pin change sets port flag.
// R19: External select disables change on shared pin.
// R20: External pins set flags on chosen edge.
// R21: Low voltage or comparator change sets flag.
// R22: ADC done and NVM write set flags.
// R23: ADC done is rising edge of complete.
// R24: Pending enabled flag vectors once enable returns.
`timescale 1ns/1ps
`include "mciw_map.vh"

module mciw_irq_wdt #(
  parameter AW          = 8,
  parameter PCW         = 11,
  parameter WDT_P0_CYC  = `MCIW_WDT_T0_US * `MCIW_CLK_MHZ,
  parameter WDT_P1_CYC  = `MCIW_WDT_T1_US * `MCIW_CLK_MHZ,
  parameter WDT_P2_CYC  = `MCIW_WDT_T2_US * `MCIW_CLK_MHZ,
  parameter WDT_P3_CYC  = `MCIW_WDT_T3_US * `MCIW_CLK_MHZ
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [AW-1:0]   paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            sw_irq_instruction,
  input  wire            enable_irq_instruction,
  input  wire            disable_irq_instruction,
  input  wire            return_from_service_instruction,
  input  wire            clear_watchdog_instruction,
  output reg             vector_take_r,
  output reg  [PCW-1:0]  vector_addr_r,
  output reg             wdt_reset_req_r,
  input  wire            cfg_wdt_enable,
  input  wire            cfg_wdt_irq_mode,
  input  wire [1:0]      cfg_wdt_period,
  input  wire            timer0_wrap,
  input  wire            timer1_underflow,
  input  wire            timer4_underflow,
  input  wire            timer5_underflow,
  input  wire            capture_compare_mode,
  input  wire            capture_compare_event,
  input  wire [7:0]      porta_in,
  input  wire [7:0]      portb_in,
  input  wire [7:0]      porta_is_input,
  input  wire [7:0]      portb_is_input,
  input  wire            lvd_below,
  input  wire            cmp_out,
  input  wire            adc_conv_complete,
  input  wire            nvm_write_done
);

  localparam NS = `MCIW_NSRC;

  // Registers
  reg [NS-1:0]  flag_r;
  reg [NS-1:0]  flag_nxt;
  reg [NS-1:0]  irq_en_r;
  reg [7:0]     pwrctl_r;
  reg [3:0]     wdtctl_r;
  reg [7:0]     extctl_r;
  reg [15:0]    chg_en_r;
  reg           gie_r;
  reg           gie_nxt;
  reg           to_n_r;

  // APB decode
  wire wr_acc = psel & penable & pwrite;
  wire rd_set = psel & ~penable & ~pwrite;
  wire hit_flag = (paddr == `MCIW_OFF_FLAG);
  wire hit_en   = (paddr == `MCIW_OFF_ENABLE);
  wire hit_pwr  = (paddr == `MCIW_OFF_PWRCTL);
  wire hit_stat = (paddr == `MCIW_OFF_STATUS);
  wire hit_wdt  = (paddr == `MCIW_OFF_WDTCTL);
  wire hit_ext  = (paddr == `MCIW_OFF_EXTCTL);
  wire hit_chg  = (paddr == `MCIW_OFF_CHGEN);
  wire mapped   = hit_flag | hit_en | hit_pwr | hit_stat |
                  hit_wdt | hit_ext | hit_chg;

  // Zero wait states; unmapped access gets an error response
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Control fields
  wire       run_en  = pwrctl_r[`MCIW_B_RUN_EN];
  wire       ps_wdt  = wdtctl_r[`MCIW_B_PSWDT];
  wire [2:0] ps_sel  = wdtctl_r[2:0];
  wire [2:0] ext_sel = extctl_r[2:0];
  wire [2:0] ext_pol = extctl_r[5:3];
  wire       ext0_alt = extctl_r[6];
  wire       ext1_alt = extctl_r[7];

  // Pin synchronisers: edges use stage two and its one-cycle-delayed copy
  reg [15:0] pin_s1_r;
  reg [15:0] pin_s2_r;
  reg [15:0] pin_prev_r;
  reg [1:0]  ana_s1_r;
  reg [1:0]  ana_s2_r;
  reg [1:0]  ana_prev_r;
  reg        adc_prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r   <= 16'h0000;
      pin_s2_r   <= 16'h0000;
      pin_prev_r <= 16'h0000;
      ana_s1_r   <= 2'h0;
      ana_s2_r   <= 2'h0;
      ana_prev_r <= 2'h0;
      adc_prev_r <= 1'b0;
    end else begin
      pin_s1_r   <= {portb_in, porta_in};
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
      ana_s1_r   <= {cmp_out, lvd_below};
      ana_s2_r   <= ana_s1_r;
      ana_prev_r <= ana_s2_r;
      adc_prev_r <= adc_conv_complete;
    end
  end

  wire [15:0] pin_rise = pin_s2_r & ~pin_prev_r;
  wire [15:0] pin_fall = ~pin_s2_r & pin_prev_r;

  // Shared pins: ext0 on PB0/PB5, ext1 on PB1/PA3, ext2 on PA5
  wire [15:0] ext_mask;
  assign ext_mask[0]  = 1'b0;
  assign ext_mask[1]  = 1'b0;
  assign ext_mask[2]  = 1'b0;
  assign ext_mask[3]  = ext_sel[1] & ext1_alt;
  assign ext_mask[4]  = 1'b0;
  assign ext_mask[5]  = ext_sel[2];
  assign ext_mask[6]  = 1'b0;
  assign ext_mask[7]  = 1'b0;
  assign ext_mask[8]  = ext_sel[0] & ~ext0_alt;
  assign ext_mask[9]  = ext_sel[1] & ~ext1_alt;
  assign ext_mask[10] = 1'b0;
  assign ext_mask[11] = 1'b0;
  assign ext_mask[12] = 1'b0;
  assign ext_mask[13] = ext_sel[0] & ext0_alt;
  assign ext_mask[14] = 1'b0;
  assign ext_mask[15] = 1'b0;

  wire [15:0] pin_dir = {portb_is_input, porta_is_input};
  wire [15:0] chg_act = pin_dir & chg_en_r & ~ext_mask; // R19
  wire pchg_evt = |((pin_rise | pin_fall) & chg_act); // R18

  // External edge sources per channel
  wire [2:0] ext_r;
  wire [2:0] ext_f;
  assign ext_r[0] = ext0_alt ? pin_rise[13] : pin_rise[8];
  assign ext_f[0] = ext0_alt ? pin_fall[13] : pin_fall[8];
  assign ext_r[1] = ext1_alt ? pin_rise[3] : pin_rise[9];
  assign ext_f[1] = ext1_alt ? pin_fall[3] : pin_fall[9];
  assign ext_r[2] = pin_rise[5];
  assign ext_f[2] = pin_fall[5];

  wire [2:0] ext_evt;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
      assign ext_evt[gi] = ext_sel[gi] &
                           (ext_pol[gi] ? ext_r[gi] : ext_f[gi]); // R20
    end
  endgenerate

  wire lvd_evt = ana_s2_r[0] & ~ana_prev_r[0];
  wire cmp_evt = ana_s2_r[1] ^ ana_prev_r[1];
  wire adc_evt = adc_conv_complete & ~adc_prev_r; // R23
  wire t5_evt  = capture_compare_mode ? capture_compare_event
                                      : timer5_underflow; // R11

  // Watchdog time base
  reg  [22:0] wdt_base_r;
  reg  [7:0]  wdt_pre_r;
  reg  [22:0] wdt_lim;
  wire        wdt_run = cfg_wdt_enable & run_en; // R17

  always @* begin
    case (cfg_wdt_period) // R14
      2'd0:    wdt_lim = WDT_P0_CYC[22:0] - 23'd1;
      2'd1:    wdt_lim = WDT_P1_CYC[22:0] - 23'd1;
      2'd2:    wdt_lim = WDT_P2_CYC[22:0] - 23'd1;
      default: wdt_lim = WDT_P3_CYC[22:0] - 23'd1;
    endcase
  end

  // Divide ratio 2^sel in reset mode, 2^(sel+1) in interrupt mode
  wire [8:0] pre_ratio = cfg_wdt_irq_mode ? (9'h002 << ps_sel)
                                          : (9'h001 << ps_sel); // R15
  wire [8:0] pre_lim   = ps_wdt ? pre_ratio - 9'h001 : 9'h000;
  wire base_tick = wdt_run & (wdt_base_r == wdt_lim);
  wire wdt_to    = base_tick & ({1'b0, wdt_pre_r} == pre_lim);
  wire wdt_clr   = clear_watchdog_instruction;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_base_r <= 23'h000000;
      wdt_pre_r  <= 8'h00;
    end else if (wdt_clr) begin
      wdt_base_r <= 23'h000000; // R16
      wdt_pre_r  <= 8'h00; // R16
    end else if (base_tick) begin
      wdt_base_r <= 23'h000000;
      wdt_pre_r  <= wdt_to ? 8'h00 : wdt_pre_r + 8'h01;
    end else if (wdt_run) begin
      wdt_base_r <= wdt_base_r + 23'h000001;
    end
  end

  // Event vector in flag bit order
  wire [NS-1:0] evt;
  assign evt[`MCIW_B_TMR0] = timer0_wrap; // R9
  assign evt[`MCIW_B_TMR1] = timer1_underflow; // R10
  assign evt[`MCIW_B_TMR4] = timer4_underflow; // R10
  assign evt[`MCIW_B_TMR5] = t5_evt;
  assign evt[`MCIW_B_PCHG] = pchg_evt;
  assign evt[`MCIW_B_EXT0] = ext_evt[0];
  assign evt[`MCIW_B_WDT]  = wdt_to & cfg_wdt_irq_mode; // R12
  assign evt[`MCIW_B_EXT1] = ext_evt[1];
  assign evt[`MCIW_B_EXT2] = ext_evt[2];
  assign evt[`MCIW_B_LVD]  = lvd_evt | cmp_evt; // R21
  assign evt[`MCIW_B_ADC]  = adc_evt; // R22
  assign evt[`MCIW_B_NVM]  = nvm_write_done; // R22

  // Sticky flags; a new event beats a same-cycle clear
  always @* begin
    flag_nxt = flag_r;
    if (wr_acc && hit_flag)
      flag_nxt = flag_r & pwdata[NS-1:0]; // R2
    flag_nxt = flag_nxt | evt; // R2
  end

  // Vectoring and global enable
  wire hw_pend = |(flag_r & irq_en_r);
  wire hw_take = gie_r & hw_pend & ~sw_irq_instruction; // R3 R24

  always @* begin
    gie_nxt = gie_r;
    if (sw_irq_instruction)
      gie_nxt = 1'b0; // R1
    else if (hw_take)
      gie_nxt = 1'b0; // R3
    else if (enable_irq_instruction || return_from_service_instruction)
      gie_nxt = 1'b1; // R4 R5
    else if (disable_irq_instruction)
      gie_nxt = 1'b0; // R4
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_r         <= 1'b0;
      vector_take_r <= 1'b0;
      vector_addr_r <= {PCW{1'b0}};
    end else begin
      gie_r         <= gie_nxt;
      vector_take_r <= sw_irq_instruction | hw_take;
      if (sw_irq_instruction)
        vector_addr_r <= `MCIW_VEC_SW; // R1
      else if (hw_take)
        vector_addr_r <= `MCIW_VEC_HW; // R3
    end
  end

  // Timeout status and reset request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_n_r          <= 1'b1;
      wdt_reset_req_r <= 1'b0;
    end else begin
      wdt_reset_req_r <= wdt_to & ~cfg_wdt_irq_mode; // R13
      if (wdt_to)
        to_n_r <= 1'b0; // R13
      else if (wdt_clr && ps_wdt)
        to_n_r <= 1'b1; // R16
    end
  end

  // Software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r   <= {NS{1'b0}};
      irq_en_r <= {NS{1'b0}};
      pwrctl_r <= `MCIW_RST_PWRCTL;
      wdtctl_r <= `MCIW_RST_WDTCTL;
      extctl_r <= `MCIW_RST_EXTCTL;
      chg_en_r <= `MCIW_RST_CHGEN;
    end else begin
      flag_r <= flag_nxt;
      if (wr_acc && hit_en)
        irq_en_r <= pwdata[NS-1:0];
      if (wr_acc && hit_pwr)
        pwrctl_r <= pwdata[7:0];
      if (wr_acc && hit_wdt)
        wdtctl_r <= pwdata[3:0];
      if (wr_acc && hit_ext)
        extctl_r <= pwdata[7:0];
      if (wr_acc && hit_chg)
        chg_en_r <= pwdata[15:0];
    end
  end

  // Read data captured in setup phase, held through access
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (1'b1)
      hit_flag: rd_val[NS-1:0] = flag_r & irq_en_r; // R6
      hit_en:   rd_val[NS-1:0] = irq_en_r;
      hit_pwr:  rd_val[7:0]    = pwrctl_r;
      hit_stat: begin
        rd_val[`MCIW_B_TO_N] = to_n_r;
        rd_val[`MCIW_B_GIE]  = gie_r;
      end
      hit_wdt:  rd_val[3:0]    = wdtctl_r;
      hit_ext:  rd_val[7:0]    = extctl_r;
      hit_chg:  rd_val[15:0]   = chg_en_r;
      default:  rd_val = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_set)
      prdata <= rd_val;
  end

endmodule

// File: testbench/mciw_checker.sv
/* Port assertions for the interrupt and watchdog block.
   Assumes watchdog config inputs stay steady while the watchdog runs. */
`timescale 1ns/1ps
module mciw_checker #(
  parameter PCW = 11
) (
  input wire           pclk,
  input wire           presetn,
  input wire           sw_irq_instruction,
  input wire           clear_watchdog_instruction,
  input wire           vector_take_r,
  input wire [PCW-1:0] vector_addr_r,
  input wire           wdt_reset_req_r,
  input wire           cfg_wdt_enable,
  input wire           cfg_wdt_irq_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sw_vector_a: assert property (sw_irq_instruction |=> vector_take_r && vector_addr_r == 11'h001)
    else $error("software vector missing");
  hw_vector_a: assert property (vector_take_r && !$past(sw_irq_instruction)
    |-> vector_addr_r == 11'h008)
    else $error("hardware vector address wrong");
  gie_clear_a: assert property (vector_take_r && !sw_irq_instruction |=> !vector_take_r)
    else $error("global enable not cleared on vector");
  addr_hold_a: assert property (!vector_take_r |-> $stable(vector_addr_r))
    else $error("vector address moved");
  wdt_mode_a: assert property (wdt_reset_req_r |-> cfg_wdt_enable && !cfg_wdt_irq_mode)
    else $error("reset request outside reset mode");
  wdt_gap_a: assert property (wdt_reset_req_r |=> !wdt_reset_req_r [*8])
    else $error("timeouts too close");
  wdt_clear_a: assert property (clear_watchdog_instruction |-> ##3 !wdt_reset_req_r [*8])
    else $error("timeout soon after clear");
  wdt_gate_a: assert property (!cfg_wdt_enable [*4] |-> !wdt_reset_req_r)
    else $error("timeout while not configured");
endmodule
bind mciw_irq_wdt mciw_checker #(.PCW(PCW)) chk_i (.pclk(pclk), .presetn(presetn),
  .sw_irq_instruction(sw_irq_instruction), .clear_watchdog_instruction(clear_watchdog_instruction),
  .vector_take_r(vector_take_r), .vector_addr_r(vector_addr_r),
  .wdt_reset_req_r(wdt_reset_req_r), .cfg_wdt_enable(cfg_wdt_enable),
  .cfg_wdt_irq_mode(cfg_wdt_irq_mode));

// File: testbench/mciw_cpu_model.sv
/* CPU core stand-in: turns one opcode request into a one-cycle strobe.
   Assumes the bench raises go for one pclk cycle per instruction. */
`timescale 1ns/1ps
module mciw_cpu_model (
  input  wire       pclk,
  input  wire [2:0] op,
  input  wire       go,
  output reg  [4:0] strobe
);
  // Firmware order left to the bench, which never issues enable right before return
  always @(posedge pclk)
    strobe <= go ? (5'h01 << op) : 5'h00;
endmodule

// File: testbench/testbench.sv
/* Self-checking bench for the interrupt and watchdog block.
   Assumes a zero-wait APB slave and pclk-synchronous event strobes. */
`timescale 1ns/1ps
module testbench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [7:0]  paddr = 0, pa = 0, pb = 0;
  reg  [31:0] pwdata = 0, rd, vcnt = 0, en;
  reg  [2:0]  op = 0;
  reg  [6:0]  ev = 0, m;
  reg         go = 0, cfg_en = 0, cfg_irq = 0, ccm = 0, lvd = 0, cmp = 0, er;
  reg  [10:0] vlast = 0;
  reg  [1:0]  per = 0;
  reg  [7:0]  pdir_a = 8'hFF, pdir_b = 8'hFF;
  integer     err_count = 0, checks = 0, i, n;
  wire [31:0] prdata;
  wire [10:0] va;
  wire [4:0]  stb;
  wire        pready, pslverr, vt, wrq;
  mciw_cpu_model cpu (.pclk(pclk), .op(op), .go(go), .strobe(stb));
  mciw_irq_wdt #(.WDT_P0_CYC(20), .WDT_P1_CYC(40), .WDT_P2_CYC(60), .WDT_P3_CYC(80)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_irq_instruction(stb[0]), .enable_irq_instruction(stb[1]),
    .disable_irq_instruction(stb[2]), .return_from_service_instruction(stb[3]),
    .clear_watchdog_instruction(stb[4]), .vector_take_r(vt), .vector_addr_r(va),
    .wdt_reset_req_r(wrq), .cfg_wdt_enable(cfg_en), .cfg_wdt_irq_mode(cfg_irq),
    .cfg_wdt_period(per), .timer0_wrap(ev[0]), .timer1_underflow(ev[1]),
    .timer4_underflow(ev[2]), .timer5_underflow(ev[3]), .capture_compare_mode(ccm),
    .capture_compare_event(ev[6]), .porta_in(pa), .portb_in(pb), .porta_is_input(pdir_a),
    .portb_is_input(pdir_b), .lvd_below(lvd), .cmp_out(cmp), .adc_conv_complete(ev[5]),
    .nvm_write_done(ev[4]));
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) if (vt) begin
    vcnt <= vcnt + 1;
    vlast <= va;
  end
  function [31:0] exp_flags(input [6:0] s, input c);
    exp_flags = {20'h0, s[4], s[5], 6'h0, (c ? s[6] : s[3]), s[2], s[1], s[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task ins(input [2:0] o);
    op <= o;
    go <= 1;
    @(posedge pclk) go <= 0;
    repeat (4) @(posedge pclk);
  endtask
  task gap(input integer p);
    n = 0;
    while (wrq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n = n + 1;
    end
    n = 0;
    @(posedge pclk);
    while (wrq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk({31'h0, n >= p - 2 && n <= p}, 32'h1);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is under a thousand cycles; generous margin
  initial begin
    #(40 * 20000);
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    i = $urandom(81392);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(8'h0C, 32'h10);
    rdc(8'h08, 32'h80);
    rdc(8'h14, 32'h38);
    apb(1, 8'h0C, 0);
    rdc(8'h0C, 32'h10);
    rdc(8'h1C, 0);
    chk({31'h0, er}, 32'h1);
    $display("test reset values done");
    for (i = 0; i < 12; i = i + 1) begin
      en = $urandom;
      m = $urandom;
      ccm <= $urandom;
      apb(1, 8'h04, en);
      ev <= m;
      @(posedge pclk) ev <= 0;
      repeat (3) @(posedge pclk);
      rdc(8'h00, exp_flags(m, ccm) & en & 32'hFFF);
      apb(1, 8'h00, 0);
    end
    $display("test event flags done");
    apb(1, 8'h04, 1);
    ev <= 1;
    @(posedge pclk) ev <= 0;
    repeat (4) @(posedge pclk);
    chk(vcnt, 0);
    ins(1);
    chk(vcnt, 1);
    chk({21'h0, vlast}, 32'h8);
    rdc(8'h0C, 32'h10);
    ins(0);
    chk({21'h0, vlast}, 32'h1);
    ins(3);
    chk(vcnt, 3);
    apb(1, 8'h00, 0);
    ins(1);
    rdc(8'h0C, 32'h11);
    ins(2);
    rdc(8'h0C, 32'h10);
    $display("test vectoring done");
    apb(1, 8'h10, 0);
    cfg_en <= 1;
    ins(4);
    gap(20);
    rdc(8'h0C, 32'h00);
    apb(1, 8'h10, 32'h0A);
    ins(4);
    rdc(8'h0C, 32'h10);
    gap(80);
    per <= 1;
    apb(1, 8'h10, 0);
    ins(4);
    gap(40);
    per <= 0;
    cfg_en <= 0;
    cfg_irq <= 1;
    apb(1, 8'h10, 32'h08);
    apb(1, 8'h04, 32'h40);
    ins(4);
    cfg_en <= 1;
    repeat (45) @(posedge pclk);
    rdc(8'h00, 32'h40);
    apb(1, 8'h08, 0);
    apb(1, 8'h00, 0);
    repeat (100) @(posedge pclk);
    rdc(8'h00, 0);
    $display("test watchdog done");
    apb(1, 8'h04, 32'h310);
    apb(1, 8'h18, 32'h21);
    apb(1, 8'h14, 32'h3C);
    pa <= 8'h20;
    repeat (5) @(posedge pclk);
    rdc(8'h00, 32'h100);
    apb(1, 8'h00, 0);
    pa <= 8'h21;
    repeat (5) @(posedge pclk);
    rdc(8'h00, 32'h10);
    apb(1, 8'h00, 0);
    pdir_a <= 8'hFE;
    pa <= 8'h20;
    repeat (5) @(posedge pclk);
    rdc(8'h00, 0);
    pdir_a <= 8'hFF;
    lvd <= 1;
    repeat (5) @(posedge pclk);
    rdc(8'h00, 32'h200);
    apb(1, 8'h00, 0);
    cmp <= 1;
    repeat (5) @(posedge pclk);
    rdc(8'h00, 32'h200);
    $display("test pins done");
    conclude;
  end
endmodule
